// >>> design/omm_irq_if.sv
// interrupt bundle between the core and the sticky status block
// assumes: both ends on the same clock
`timescale 1ns/100ps
`default_nettype none
interface omm_irq_if #(parameter int N = 4);
  logic [N-1:0] evt;
  logic [N-1:0] wdata;
  logic clrWe;
  logic maskWe;
  logic [N-1:0] status;
  logic [N-1:0] mask;
  logic irq;
  modport core (output evt, wdata, clrWe, maskWe,
    input status, mask, irq);
  modport sticky (input evt, wdata, clrWe, maskWe,
    output status, mask, irq);
endinterface
`default_nettype wire

// >>> design/omm_pkg.sv
// constants, register map and state codes of the optical module management
// assumes: imported by omm_top and its bench only
package omm_pkg;
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_MADDR = 8'h0C;
  localparam logic [7:0] REG_MDATA = 8'h10;
  localparam logic [7:0] REG_PINS = 8'h14;
  // control fields and the value of the extcal field after reset
  localparam int CTRL_EXTCAL = 0;
  localparam int CTRL_LOCK = 1;
  localparam logic CTRL_EXTCAL_RST = 1'b1;
  // serial device addresses, 7 bit
  localparam logic [6:0] DEV_ID = 7'h50;
  localparam logic [6:0] DEV_DIAG = 7'h51;
  // diagnostics page layout
  localparam logic [7:0] DIAG_CAL_LO = 8'h38;
  localparam logic [7:0] DIAG_CAL_HI = 8'h5F;
  localparam logic [7:0] DIAG_TYPE = 8'h5C;
  localparam int DIAG_TYPE_EXTCAL = 4;
  localparam logic [7:0] MON_BASE = 8'h60;
  localparam logic [7:0] MON_HI = 8'h69;
  localparam logic [7:0] DIAG_STAT = 8'h6E;
  localparam logic [7:0] USER_BASE = 8'h80;
  // interrupt events
  localparam int EVT_N = 4;
  localparam int EVT_FAULT = 0;
  localparam int EVT_RXLOW = 1;
  localparam int EVT_WRITE = 2;
  localparam int EVT_STOP = 3;
  // synchroniser reset: {sda, scl, rxLow, fault, txOff}
  localparam logic [4:0] PIN_RST = 5'h19;
  // serial engine states
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, ST_DEV = 9'h002, ST_ACKDEV = 9'h004,
    ST_WADDR = 9'h008, ST_ACKA = 9'h010, ST_WDATA = 9'h020,
    ST_ACKW = 9'h040, ST_RDATA = 9'h080, ST_RACK = 9'h100
  } omm_state_e;
endpackage

// >>> design/omm_sync.sv
// two flip-flop synchroniser and sticky interrupt status
// assumes: inputs come from outside the clk domain
`timescale 1ns/100ps
`default_nettype none
module omm_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= RST;
      dout <= RST;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // omm_sync

module omm_irq #(parameter int N = 4) (
  input wire logic clk,
  input wire logic reset_n,
  omm_irq_if.sticky bus
);
  logic [N-1:0] status, mask, next_status, next_mask;
  // set wins over a write-one clear in the same cycle
  always_comb begin
    next_status = status;
    if (bus.clrWe) next_status = next_status & ~bus.wdata;
    next_status = next_status | bus.evt;
    next_mask = bus.maskWe ? bus.wdata : mask;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= '0;
      mask <= '0;
    end else begin
      status <= next_status;
      mask <= next_mask;
    end
  end
  assign bus.status = status;
  assign bus.mask = mask;
  assign bus.irq = |(status & mask);
  property p_set_wins;
    @(posedge clk) disable iff (!reset_n) bus.evt[0] |=> status[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");
endmodule // omm_irq
`default_nettype wire

// >>> design/omm_top.sv
// optical module management: sideband pins, serial id/diag memory, apb
// assumes: host drives scl; pins are asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module omm_top import omm_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txShutoff,
  input wire logic laserFaultDetect,
  input wire logic rxPowerLowDetect,
  output logic laserOff,
  output logic laserFault,
  output logic laserFaultOe,
  output logic receivePowerLow,
  output logic receivePowerLowOe,
  output logic modulePresence,
  output logic modulePresenceOe,
  input wire logic receiveRateSelect,
  input wire logic transmitRateSelect,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [15:0] monTemp,
  input wire logic [15:0] monVcc,
  input wire logic [15:0] monBias,
  input wire logic [15:0] monTxPower,
  input wire logic [15:0] monRxPower,
  input wire logic monValid,
  output logic irq
);
  logic [4:0] pinS;
  logic txOffS, faultS, rxLowS, sclS, sdaS;
  logic sclD, sdaD, sclRise, sclFall, start, stop;
  logic faultQ, rxLowQ, next_laserOff, next_faultQ, next_rxLowQ;
  logic [79:0] monAll, next_monAll;
  logic [7:0] mem [512];
  omm_state_e state, next_state;
  logic [3:0] bitCnt, next_bitCnt;
  logic [7:0] shreg, next_shreg, ptr, next_ptr, rdByte, monByte;
  logic page, next_page, rnw, next_rnw, nack, next_nack;
  logic sdaLow, next_sdaLow, serWe, writable, isMon;
  logic [6:0] monShift;
  logic extCal, next_extCal, lock, next_lock;
  logic [8:0] memAddr, next_memAddr;
  logic [31:0] next_prdata;
  logic next_pslverr, setup, access, mapped, apbWe;
  omm_irq_if #(.N(EVT_N)) irqBus ();

  // pins from outside pass two flops first
  omm_sync #(.W(5), .RST(PIN_RST)) uSync (
    .clk(clk),
    .reset_n(reset_n),
    .din({sdaIn, scl, rxPowerLowDetect, laserFaultDetect, txShutoff}),
    .dout(pinS)
  );
  assign txOffS = pinS[0];
  assign faultS = pinS[1];
  assign rxLowS = pinS[2];
  assign sclS = pinS[3];
  assign sdaS = pinS[4];

  // serial line conditions from the synchronised scl and sda
  assign sclRise = sclS & ~sclD;
  assign sclFall = ~sclS & sclD;
  assign start = sclS & sclD & sdaD & ~sdaS;
  assign stop = sclS & sclD & ~sdaD & sdaS;

  // sideband flags; rate selects are left unread
  always_comb begin
    next_laserOff = txOffS;
    next_faultQ = faultS;
    next_rxLowQ = rxLowS;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
      laserOff <= 1'b1;
      faultQ <= 1'b1;
      rxLowQ <= 1'b1;
    end else begin
      sclD <= sclS;
      sdaD <= sdaS;
      laserOff <= next_laserOff;
      faultQ <= next_faultQ;
      rxLowQ <= next_rxLowQ;
    end
  end
  // open-drain flags: released means high at the host
  assign laserFault = 1'b0;
  assign laserFaultOe = ~faultQ;
  assign receivePowerLow = 1'b0;
  assign receivePowerLowOe = ~rxLowQ;
  assign modulePresence = 1'b0;
  assign modulePresenceOe = 1'b1;
  // the module only ever pulls sda low, never scl
  assign sdaOut = 1'b0;
  assign sdaOe = sdaLow;

  // monitor samples, raw converter codes
  always_comb begin
    next_monAll = monAll;
    if (monValid) begin
      next_monAll = {monTemp, monVcc, monBias, monTxPower, monRxPower};
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) monAll <= '0;
    else monAll <= next_monAll;
  end

  // byte seen by the serial reader at the current pointer
  always_comb begin
    isMon = page && ptr >= MON_BASE && ptr <= MON_HI;
    monShift = 7'(8 * (9 - int'(ptr[3:0])));
    monByte = 8'(monAll >> monShift);
    rdByte = mem[{page, ptr}];
    if (isMon) rdByte = monByte;
    else if (page && ptr == DIAG_STAT) begin
      rdByte = {laserOff, 4'h0, faultQ, rxLowQ, 1'b0};
    end else if (page && ptr == DIAG_TYPE) begin
      rdByte[DIAG_TYPE_EXTCAL] = extCal;
    end
  end
  // only the user area of the diag page takes serial writes
  assign writable = page && ptr >= USER_BASE;

  // serial engine: shift in on rise, act and drive on fall
  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_page = page;
    next_rnw = rnw;
    next_nack = nack;
    next_sdaLow = sdaLow;
    serWe = 1'b0;
    if (stop) begin
      next_state = ST_IDLE;
      next_sdaLow = 1'b0;
    end else if (start) begin
      next_state = ST_DEV;
      next_bitCnt = 4'h0;
      next_sdaLow = 1'b0;
    end else begin
      if (sclRise) begin
        if (state == ST_DEV || state == ST_WADDR || state == ST_WDATA) begin
          next_shreg = {shreg[6:0], sdaS};
          next_bitCnt = 4'(bitCnt + 1);
        end else if (state == ST_RDATA) begin
          next_bitCnt = 4'(bitCnt + 1);
        end else if (state == ST_RACK) begin
          next_nack = sdaS;
        end
      end
      if (sclFall) begin
        case (state)
          ST_DEV: begin
            if (bitCnt == 4'h8) begin
              next_bitCnt = 4'h0;
              if (shreg[7:1] == DEV_ID || shreg[7:1] == DEV_DIAG) begin
                next_page = shreg[1];
                next_rnw = shreg[0];
                next_sdaLow = 1'b1;
                next_state = ST_ACKDEV;
              end else begin
                next_state = ST_IDLE;
              end
            end
          end
          ST_ACKDEV: begin
            if (rnw) begin
              next_shreg = rdByte;
              next_sdaLow = ~rdByte[7];
              next_state = ST_RDATA;
            end else begin
              next_sdaLow = 1'b0;
              next_state = ST_WADDR;
            end
          end
          ST_WADDR: begin
            if (bitCnt == 4'h8) begin
              next_ptr = shreg;
              next_bitCnt = 4'h0;
              next_sdaLow = 1'b1;
              next_state = ST_ACKA;
            end
          end
          ST_WDATA: begin
            if (bitCnt == 4'h8) begin
              serWe = writable;
              next_ptr = 8'(ptr + 1);
              next_bitCnt = 4'h0;
              next_sdaLow = 1'b1;
              next_state = ST_ACKW;
            end
          end
          ST_ACKA, ST_ACKW: begin
            next_sdaLow = 1'b0;
            next_state = ST_WDATA;
          end
          ST_RDATA: begin
            if (bitCnt == 4'h8) begin
              next_ptr = 8'(ptr + 1);
              next_bitCnt = 4'h0;
              next_sdaLow = 1'b0;
              next_state = ST_RACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sdaLow = ~shreg[6];
            end
          end
          ST_RACK: begin
            if (nack) begin
              next_state = ST_IDLE;
            end else begin
              next_shreg = rdByte;
              next_sdaLow = ~rdByte[7];
              next_state = ST_RDATA;
            end
          end
          ST_IDLE: next_state = ST_IDLE;
          default: next_state = ST_IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      page <= 1'b0;
      rnw <= 1'b0;
      nack <= 1'b0;
      sdaLow <= 1'b0;
    end else begin
      state <= next_state;
      bitCnt <= next_bitCnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      page <= next_page;
      rnw <= next_rnw;
      nack <= next_nack;
      sdaLow <= next_sdaLow;
    end
  end

  // memory: factory load over apb until locked, user area by serial
  always_ff @(posedge clk) begin
    if (apbWe) mem[memAddr] <= pwdata[7:0];
    if (serWe) mem[{page, ptr}] <= shreg;
  end

  // apb slave, zero wait states, data prepared in the setup cycle
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign mapped = paddr == REG_CTRL || paddr == REG_STATUS ||
    paddr == REG_MASK || paddr == REG_MADDR || paddr == REG_MDATA ||
    paddr == REG_PINS;
  assign apbWe = access & pwrite & paddr == REG_MDATA & ~lock;
  assign irqBus.wdata = pwdata[EVT_N-1:0];
  assign irqBus.clrWe = access & pwrite & paddr == REG_STATUS;
  assign irqBus.maskWe = access & pwrite & paddr == REG_MASK;
  assign irqBus.evt[EVT_FAULT] = faultS & ~faultQ;
  assign irqBus.evt[EVT_RXLOW] = rxLowS & ~rxLowQ;
  assign irqBus.evt[EVT_WRITE] = serWe;
  assign irqBus.evt[EVT_STOP] = stop;
  assign irq = irqBus.irq;
  omm_irq #(.N(EVT_N)) uIrq (
    .clk(clk),
    .reset_n(reset_n),
    .bus(irqBus.sticky)
  );

  // register writes and read data
  always_comb begin
    next_extCal = extCal;
    next_lock = lock;
    next_memAddr = memAddr;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (access & pwrite) begin
      if (paddr == REG_CTRL) begin
        next_extCal = pwdata[CTRL_EXTCAL];
        next_lock = lock | pwdata[CTRL_LOCK];
      end
      if (paddr == REG_MADDR) next_memAddr = pwdata[8:0];
      if (apbWe) next_memAddr = 9'(memAddr + 1);
    end
    if (setup) begin
      next_pslverr = ~mapped;
      case (paddr)
        REG_CTRL: next_prdata = {30'h0, lock, extCal};
        REG_STATUS: next_prdata = {28'h0, irqBus.status};
        REG_MASK: next_prdata = {28'h0, irqBus.mask};
        REG_MADDR: next_prdata = {23'h0, memAddr};
        REG_MDATA: next_prdata = {24'h0, mem[memAddr]};
        REG_PINS: next_prdata = {29'h0, rxLowQ, faultQ, laserOff};
        default: next_prdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extCal <= CTRL_EXTCAL_RST;
      lock <= 1'b0;
      memAddr <= 9'h000;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      extCal <= next_extCal;
      lock <= next_lock;
      memAddr <= next_memAddr;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_tx_off;
    txShutoff [*3] |=> laserOff;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("laser on");
  property p_tx_on;
    !txShutoff [*3] |=> !laserOff;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("laser off");
  property p_fault;
    laserFaultDetect [*3] |=> !laserFaultOe;
  endproperty
  a_fault: assert property (p_fault) else $error("no fault");
  property p_rxlow;
    rxPowerLowDetect [*3] |=> !receivePowerLowOe;
  endproperty
  a_rxlow: assert property (p_rxlow) else $error("no rx low");
  property p_present;
    modulePresenceOe && !modulePresence;
  endproperty
  a_present: assert property (p_present) else $error("absent");
  property p_protect;
    serWe |-> page && ptr >= USER_BASE;
  endproperty
  a_protect: assert property (p_protect) else $error("prot wr");
  property p_fall_drive;
    $changed(sdaLow) && !$past(start) && !$past(stop) |-> $past(sclFall);
  endproperty
  a_fall_drive: assert property (p_fall_drive) else $error("sda");
  property p_start;
    start && !stop |=> state == ST_DEV && bitCnt == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_seq;
    serWe |=> ptr == 8'($past(ptr) + 8'h01);
  endproperty
  a_seq: assert property (p_seq) else $error("no increment");
  property p_mon;
    monValid |=> monAll[79:64] == $past(monTemp);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor");
  property p_ack;
    state == ST_ACKDEV |-> sdaLow;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  c_write: cover property (serWe);
  c_read: cover property (state == ST_RACK && sclRise && !sdaS);
  c_irq: cover property ($rose(irq));
endmodule // omm_top
`default_nettype wire

// >>> test/omm_host_model.sv
// host side of the serial link: makes scl and pulls sda low
// assumes: sda is the resolved wire level, clk is the bench clock
`timescale 1ns/100ps
`default_nettype none
module omm_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sdaPull
);
  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // quarter of a 160 ns bit
  task automatic q();
    repeat (10) @(posedge clk);
  endtask
  // start or repeated start, data falls while clock high
  task automatic start();
    sdaPull <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sdaPull <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  // stop, data rises while clock high
  task automatic stop();
    sdaPull <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sdaPull <= 1'b0;
    q();
  endtask
  task automatic bitOut(input logic b);
    sdaPull <= ~b;
    q();
    scl <= 1'b1;
    q();
    q();
    scl <= 1'b0;
    q();
  endtask
  // sample early and late in the high phase to catch early changes
  task automatic bitIn(output logic b, output logic st);
    sdaPull <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    b = sda;
    q();
    st = (sda === b);
    scl <= 1'b0;
    q();
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic b;
    logic st;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(b, st);
    ack = ~b;
  endtask
  task automatic rdByte(input logic last, output logic [7:0] d,
    output logic steady);
    logic st;
    steady = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      bitIn(d[i], st);
      steady = steady & st;
    end
    bitOut(last);
  endtask
endmodule // omm_host_model
`default_nettype wire

// >>> test/omm_top_tb.sv
// self-checking bench of the module management block
// assumes: host model drives the serial link, bench drives apb and pins
`timescale 1ns/100ps
`default_nettype none
module omm_top_tb import omm_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, laserOff, laserFault, laserFaultOe, irq;
  logic receivePowerLow, receivePowerLowOe, modulePresence;
  logic modulePresenceOe, scl, hostPull, sdaOut, sdaOe, sdaWire;
  logic txShutoff = 1'b1, laserFaultDetect = 1'b0;
  logic rxPowerLowDetect = 1'b0, monValid = 1'b0;
  logic receiveRateSelect = 1'b0, transmitRateSelect = 1'b0;
  logic [15:0] monTemp = 16'h0, monVcc = 16'h0, monBias = 16'h0;
  logic [15:0] monTxPower = 16'h0, monRxPower = 16'h0;
  int numErrors = 0;
  int checksDone = 0;
  int cycles = 0;
  // open-drain data wire with pull-up
  assign sdaWire = ~((sdaOe & ~sdaOut) | hostPull);
  omm_top dut_u (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .txShutoff, .laserFaultDetect,
    .rxPowerLowDetect, .laserOff, .laserFault, .laserFaultOe,
    .receivePowerLow, .receivePowerLowOe, .modulePresence,
    .modulePresenceOe, .receiveRateSelect, .transmitRateSelect, .scl,
    .sdaIn(sdaWire), .sdaOut, .sdaOe, .monTemp, .monVcc, .monBias,
    .monTxPower, .monRxPower, .monValid, .irq);
  omm_host_model host_u (.clk, .sda(sdaWire), .scl, .sdaPull(hostPull));
  // 250 MHz clock
  always #2 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      numErrors = numErrors + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
    input logic expErr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
    chk(err, expErr);
  endtask
  // address phase of a serial access: device then word address
  task automatic sAddr(input logic [6:0] dev, input logic [7:0] a);
    logic ack;
    host_u.start();
    host_u.wrByte({dev, 1'b0}, ack);
    chk(ack, 1'b1);
    host_u.wrByte(a, ack);
    chk(ack, 1'b1);
  endtask
  task automatic sWrite(input logic [6:0] dev, input logic [7:0] a,
    input logic [7:0] d);
    logic ack;
    sAddr(dev, a);
    host_u.wrByte(d, ack);
    chk(ack, 1'b1);
    host_u.stop();
  endtask
  // sequential read of n bytes, expected bytes msb first in exp
  task automatic sRead(input logic [6:0] dev, input logic [7:0] a,
    input int n, input logic [79:0] exp);
    logic [7:0] d;
    logic ack;
    logic st;
    sAddr(dev, a);
    host_u.start();
    host_u.wrByte({dev, 1'b1}, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      host_u.rdByte(i == n - 1, d, st);
      chk(d, exp[8 * (n - 1 - i) +: 8]);
      chk(st, 1'b1);
    end
    host_u.stop();
  endtask
  // register reset values and an unmapped offset
  task automatic tRegs();
    rdChk(REG_CTRL, {31'h0, CTRL_EXTCAL_RST}, 1'b0);
    rdChk(REG_MASK, 32'h0, 1'b0);
    rdChk(REG_STATUS, 32'h0, 1'b0);
    wr(8'h18, 32'hFFFFFFFF);
    rdChk(8'h18, 32'h0, 1'b1);
  endtask
  // sideband pins through the synchroniser
  task automatic tPins();
    txShutoff <= 1'b0;
    waitClk(5);
    chk(laserOff, 1'b0);
    receiveRateSelect <= 1'b1;
    transmitRateSelect <= 1'b1;
    waitClk(5);
    chk(laserOff, 1'b0);
    chk(laserFaultOe, 1'b1);
    chk(receivePowerLowOe, 1'b1);
    chk({laserFault, receivePowerLow, sdaOut}, 32'h0);
    chk({modulePresence, modulePresenceOe}, 32'h1);
    txShutoff <= 1'b1;
    waitClk(5);
    chk(laserOff, 1'b1);
  endtask
  // events set sticky bits, mask gates irq, write one clears
  task automatic tIrq();
    laserFaultDetect <= 1'b1;
    rxPowerLowDetect <= 1'b1;
    waitClk(5);
    chk(laserFaultOe, 1'b0);
    chk(receivePowerLowOe, 1'b0);
    rdChk(REG_STATUS, 32'h3, 1'b0);
    chk(irq, 1'b0);
    wr(REG_MASK, 32'h1);
    waitClk(2);
    chk(irq, 1'b1);
    wr(REG_STATUS, 32'h1);
    waitClk(2);
    chk(irq, 1'b0);
    rdChk(REG_STATUS, 32'h2, 1'b0);
    laserFaultDetect <= 1'b0;
    rxPowerLowDetect <= 1'b0;
    wr(REG_STATUS, 32'hF);
  endtask
  // factory load, lock, then serial read of both pages
  task automatic tLoad();
    wr(REG_MADDR, 32'h000);
    wr(REG_MDATA, 32'h03);
    wr(REG_MDATA, 32'h04);
    wr(REG_MADDR, {23'h0, 1'b1, DIAG_CAL_LO});
    wr(REG_MDATA, 32'h5A);
    wr(REG_MADDR, {23'h0, 1'b1, DIAG_TYPE});
    wr(REG_MDATA, 32'h00);
    wr(REG_CTRL, 32'h3);
    wr(REG_MADDR, {23'h0, 1'b1, DIAG_CAL_LO});
    wr(REG_MDATA, 32'hFF);
    rdChk(REG_MDATA, 32'h5A, 1'b0);
    sRead(DEV_ID, 8'h00, 2, 80'h0304);
    sRead(DEV_DIAG, DIAG_CAL_LO, 1, 80'h5A);
    sRead(DEV_DIAG, DIAG_TYPE, 1, 80'h1 << DIAG_TYPE_EXTCAL);
    // internal mode: flag bit clears, lock stays set
    wr(REG_CTRL, 32'h2);
    rdChk(REG_CTRL, 32'h2, 1'b0);
    sRead(DEV_DIAG, DIAG_TYPE, 1, 80'h0);
  endtask
  // serial writes: user area stored, id page protected, stray device
  task automatic tSerialWr();
    logic ack;
    sWrite(DEV_DIAG, USER_BASE, 8'hC3);
    sRead(DEV_DIAG, USER_BASE, 1, 80'hC3);
    rdChk(REG_STATUS, 32'hC, 1'b0);
    sWrite(DEV_ID, 8'h00, 8'hEE);
    sRead(DEV_ID, 8'h00, 1, 80'h03);
    host_u.start();
    host_u.wrByte({7'h52, 1'b0}, ack);
    chk(ack, 1'b0);
    host_u.stop();
  endtask
  // latched monitor codes read back raw, big-endian
  task automatic tMon();
    monTemp <= 16'h1234;
    monVcc <= 16'h5678;
    monBias <= 16'h9ABC;
    monTxPower <= 16'hDEF0;
    monRxPower <= 16'h0F1E;
    monValid <= 1'b1;
    @(posedge clk);
    monValid <= 1'b0;
    sRead(DEV_DIAG, MON_BASE, 10, 80'h123456789ABCDEF00F1E);
    // status byte: laser off, no fault, power fine
    sRead(DEV_DIAG, DIAG_STAT, 1, 80'h80);
  endtask
  // mid-run reset: outputs at reset levels, lock and mask cleared
  task automatic tReset();
    reset_n <= 1'b0;
    waitClk(2);
    chk({laserOff, laserFaultOe, receivePowerLowOe}, 32'h4);
    chk({sdaOe, irq, pslverr}, 32'h0);
    chk(prdata, 32'h0);
    reset_n <= 1'b1;
    rdChk(REG_CTRL, {31'h0, CTRL_EXTCAL_RST}, 1'b0);
    rdChk(REG_MASK, 32'h0, 1'b0);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    tRegs();
    tPins();
    tIrq();
    tLoad();
    tSerialWr();
    tMon();
    tReset();
    tally_and_finish();
  end
endmodule // omm_top_tb
`default_nettype wire
